// ==== hw/prio_int_defines.vh ====
// constants for the priority interrupt block with real-time clock
`ifndef PRIO_INT_DEFINES_VH
`define PRIO_INT_DEFINES_VH

`define LEVELS          8
`define VEC_W           8
`define ENABLE_DEV_ADDR 8'h17
`define VEC_SHIFT       3
`define RTC_LEVEL       3'h7
`define RTC_PERIOD_US   10000
`define CLK_PERIOD_NS   4
`define RTC_CYCLES      ((`RTC_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define RTC_CNT_W       32

`define ADDR_W          8
`define REG_INT_STATUS  8'h00
`define REG_INT_MASK    8'h04
`define REG_ENABLE      8'h08
`define REG_STATE       8'h0C
`define REG_CONTROL     8'h10

`define CTRL_MASK_ALL   0
`define CTRL_UNMASK_ALL 1
`define STATE_GMASK     8
`define STATE_HOLD      9
`define STATE_STRAP     10

`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`define RST_ENABLE      8'h00
`define RST_WORD        32'h0000_0000
`define ONLY_LEVEL0     8'h01
`define ALL_LEVELS      8'hFF

`endif

// ==== hw/rtc_timer.v ====
// restartable real-time clock pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "prio_int_defines.vh"

module rtc_timer #(
  parameter [`RTC_CNT_W-1:0] PERIOD = `RTC_CYCLES
) (
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  // control
  input  wire restart,
  // periodic pulse
  output reg  tick
);

  reg [`RTC_CNT_W-1:0] count_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= {`RTC_CNT_W{1'b0}};
      tick    <= 1'b0;
    end else if (restart) begin
      // triggerable: first pulse one full period after restart
      count_q <= {`RTC_CNT_W{1'b0}};
      tick    <= 1'b0;
    end else if (count_q == PERIOD - 1'b1) begin
      count_q <= {`RTC_CNT_W{1'b0}};
      tick    <= 1'b1;
    end else begin
      count_q <= count_q + 1'b1;
      tick    <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== hw/prio_int.v ====
// eight-level priority interrupt logic with real-time clock and axi4-lite registers
// How it works
// - levels 1-7 masked as group and enabled singly by output to address 0x17
// - level 0 is never blocked by global mask or enable mask
// - recognition pulse issued at the moment the level is recognised
// - highest eligible level wins, 7 down to 0, only at recognition
// - first routine instruction is never interrupted; afterwards any eligible level may
// - disabled or masked requests stay pending until enabled and unmasked
// - recognition only at completion of the instruction in progress
// - vector address is eight times the recognised level, page zero
// - real-time clock gives a periodic pulse, 10 ms by default
// - with strap fitted, clock acts as level 7, cleared by level 7 recognition
// - clock interval restarts when level 7 becomes both unmasked and enabled
// - mask-all sets the global mask, blocking all but level 0
// - unmask-all clears global mask, eligible levels may interrupt right after
// - enable byte: bit 0 drives watchdog, bits 1-7 enable matching levels
// - return-with-unmask returns and clears global mask in one instruction
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "prio_int_defines.vh"

module prio_int #(
  parameter [`RTC_CNT_W-1:0] RTC_CYCLES = `RTC_CYCLES
) (
  // clock and reset
  input  wire                 aclk,
  input  wire                 aresetn,
  // axi4-lite write address
  input  wire [`ADDR_W-1:0]   s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output reg                  s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output reg                  s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  // axi4-lite read address
  input  wire [`ADDR_W-1:0]   s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output reg                  s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready,
  // request flags from interface cards, pins
  input  wire [`LEVELS-1:0]   level_req,
  input  wire                 rtc_strap,
  // processor core, same clock
  input  wire                 instr_done,
  input  wire                 mask_all_instr,
  input  wire                 unmask_all_instr,
  input  wire                 return_unmask_instr,
  input  wire                 out_strobe,
  input  wire [`ADDR_W-1:0]   out_dev,
  input  wire [7:0]           out_data,
  // recognition and vector
  output reg  [`LEVELS-1:0]   level_ack,
  output reg                  vector_valid,
  output reg  [`VEC_W-1:0]    vector_addr,
  // misc outputs
  output reg                  watchdog,
  output reg                  rtc_pulse,
  output reg                  irq
);

  // pin synchronisers
  reg  [`LEVELS-1:0] req_s1_q;
  reg  [`LEVELS-1:0] req_s2_q;
  reg                strap_s1_q;
  reg                strap_s2_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      req_s1_q   <= {`LEVELS{1'b0}};
      req_s2_q   <= {`LEVELS{1'b0}};
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      req_s1_q   <= level_req;
      req_s2_q   <= req_s1_q;
      strap_s1_q <= rtc_strap;
      strap_s2_q <= strap_s1_q;
    end
  end

  // control state
  reg                gmask_q;
  reg                gmask_d;
  reg  [7:0]         enable_q;
  reg  [7:0]         enable_d;
  reg                hold_q;
  reg                rtc_req_q;
  reg                l7_open_q;
  reg  [`LEVELS-1:0] status_q;
  reg  [`LEVELS-1:0] imask_q;

  // axi write side
  reg                aw_got_q;
  reg                w_got_q;
  reg  [`ADDR_W-1:0] awaddr_q;
  reg  [31:0]        wdata_q;
  reg  [3:0]         wstrb_q;
  wire               wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  wire               wr_lane0 = wr_fire && wstrb_q[0];
  wire               wr_ctrl = wr_lane0 && (awaddr_q == `REG_CONTROL);
  wire               wr_en_reg = wr_lane0 && (awaddr_q == `REG_ENABLE);
  wire               wr_stat = wr_lane0 && (awaddr_q == `REG_INT_STATUS);
  wire               wr_imask = wr_lane0 && (awaddr_q == `REG_INT_MASK);
  wire               wr_known = (awaddr_q == `REG_CONTROL) || (awaddr_q == `REG_ENABLE) ||
                                (awaddr_q == `REG_INT_STATUS) ||
                                (awaddr_q == `REG_INT_MASK) || (awaddr_q == `REG_STATE);
  wire               cpu_en_wr = out_strobe && (out_dev == `ENABLE_DEV_ADDR);

  // next global mask and enables; core instructions win over software writes
  always @* begin
    gmask_d = gmask_q;
    if (mask_all_instr)
      gmask_d = 1'b1;
    else if (unmask_all_instr || return_unmask_instr)
      gmask_d = 1'b0;
    else if (wr_ctrl && wdata_q[`CTRL_MASK_ALL])
      gmask_d = 1'b1;
    else if (wr_ctrl && wdata_q[`CTRL_UNMASK_ALL])
      gmask_d = 1'b0;
    enable_d = enable_q;
    if (cpu_en_wr)
      enable_d = out_data;
    else if (wr_en_reg)
      enable_d = wdata_q[7:0];
  end

  // eligibility uses the next mask, so an unmask takes effect at its own boundary
  wire [`LEVELS-1:0] req_lvl = {strap_s2_q ? rtc_req_q : req_s2_q[`LEVELS-1],
                                req_s2_q[`LEVELS-2:0]};
  wire [`LEVELS-1:0] en_mask = {enable_d[7:1], 1'b1};
  wire [`LEVELS-1:0] gm_mask = gmask_d ? `ONLY_LEVEL0 : `ALL_LEVELS;
  wire [`LEVELS-1:0] elig = req_lvl & en_mask & gm_mask;
  wire               take = instr_done && !hold_q && (|elig);

  reg  [2:0]         sel;
  integer            i;
  always @* begin
    sel = 3'h0;
    for (i = 0; i < `LEVELS; i = i + 1) begin
      if (elig[i])
        sel = i[2:0];
    end
  end

  wire               l7_open_d = enable_d[7] && !gmask_d;
  wire               rtc_restart = l7_open_d && !l7_open_q;
  wire               rtc_tick;

  rtc_timer #(
    .PERIOD (RTC_CYCLES)
  ) u_rtc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (rtc_restart),
    .tick    (rtc_tick)
  );

  // recognition, vectoring and interrupt core
  always @(posedge aclk) begin
    if (!aresetn) begin
      gmask_q      <= 1'b0;
      enable_q     <= `RST_ENABLE;
      hold_q       <= 1'b0;
      rtc_req_q    <= 1'b0;
      l7_open_q    <= 1'b0;
      level_ack    <= {`LEVELS{1'b0}};
      vector_valid <= 1'b0;
      vector_addr  <= {`VEC_W{1'b0}};
      watchdog     <= 1'b0;
      rtc_pulse    <= 1'b0;
    end else begin
      gmask_q      <= gmask_d;
      enable_q     <= enable_d;
      watchdog     <= enable_d[0];
      l7_open_q    <= l7_open_d;
      rtc_pulse    <= rtc_tick;
      level_ack    <= take ? (`ONLY_LEVEL0 << sel) : {`LEVELS{1'b0}};
      vector_valid <= take;
      if (take)
        vector_addr <= {{(`VEC_W-3-`VEC_SHIFT){1'b0}}, sel, {`VEC_SHIFT{1'b0}}};
      // first routine instruction runs without interruption
      if (take)
        hold_q <= 1'b1;
      else if (instr_done)
        hold_q <= 1'b0;
      // clock request: a new tick wins over its own clear
      if (rtc_tick)
        rtc_req_q <= 1'b1;
      else if (take && sel == `RTC_LEVEL)
        rtc_req_q <= 1'b0;
    end
  end

  // sticky recognition events, write one to clear, set wins
  wire [`LEVELS-1:0] ev = take ? (`ONLY_LEVEL0 << sel) : {`LEVELS{1'b0}};
  wire [`LEVELS-1:0] st_clr = wr_stat ? wdata_q[`LEVELS-1:0] : {`LEVELS{1'b0}};
  // irq follows next status and mask, so a clear drops it without an extra cycle
  wire [`LEVELS-1:0] status_d = ev | (status_q & ~st_clr);
  wire [`LEVELS-1:0] imask_d = wr_imask ? wdata_q[`LEVELS-1:0] : imask_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= {`LEVELS{1'b0}};
      imask_q  <= {`LEVELS{1'b0}};
      irq      <= 1'b0;
    end else begin
      status_q <= status_d;
      imask_q  <= imask_d;
      irq      <= |(status_d & imask_d);
    end
  end

  // axi write channel: address and data accepted in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= {`ADDR_W{1'b0}};
      wdata_q       <= `RST_WORD;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_got_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q      <= 1'b1;
        awaddr_q      <= {s_axi_awaddr[`ADDR_W-1:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q      <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read channel; unmapped reads answer slverr with zero data
  wire [`ADDR_W-1:0] raddr = {s_axi_araddr[`ADDR_W-1:2], 2'b00};
  reg  [31:0]        rd_word;
  reg                rd_ok;
  always @* begin
    rd_word = `RST_WORD;
    rd_ok   = 1'b1;
    case (raddr)
      `REG_INT_STATUS: rd_word[`LEVELS-1:0] = status_q;
      `REG_INT_MASK:   rd_word[`LEVELS-1:0] = imask_q;
      `REG_ENABLE:     rd_word[7:0] = enable_q;
      `REG_STATE: begin
        rd_word[`LEVELS-1:0]  = req_lvl;
        rd_word[`STATE_GMASK] = gmask_q;
        rd_word[`STATE_HOLD]  = hold_q;
        rd_word[`STATE_STRAP] = strap_s2_q;
      end
      `REG_CONTROL:    rd_word = `RST_WORD;
      default:         rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `RST_WORD;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !s_axi_arvalid ? 1'b0 :
                       (!s_axi_arready && !s_axi_rvalid);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== testbench/card_model.sv ====
// interface card request flags facing the priority interrupt block
`timescale 1ns/1ps
`default_nettype none
module card_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench sets flags, recognition clears them
  input  wire logic [7:0] set_req,
  input  wire logic [7:0] level_ack,
  output var  logic [7:0] level_req
);
  // a new request in the clearing cycle must not be lost, so set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) level_req <= 8'h00;
    else level_req <= (level_req & ~level_ack) | set_req;
  end
endmodule
`default_nettype wire

// ==== testbench/prio_int_chk.sv ====
// assertion checker for the priority interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "prio_int_defines.vh"
module prio_int_chk #(
  parameter [`RTC_CNT_W-1:0] RTC_CYCLES = `RTC_CYCLES
) (
  // clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // core side
  input wire logic               instr_done,
  input wire logic               mask_all_instr,
  input wire logic               unmask_all_instr,
  input wire logic               return_unmask_instr,
  // recognition and clock
  input wire logic [`LEVELS-1:0] level_ack,
  input wire logic               vector_valid,
  input wire logic [`VEC_W-1:0]  vector_addr,
  input wire logic               rtc_pulse
);
  logic        pend_q;
  logic        seen_q;
  logic [31:0] gap_q;
  // restarts only stretch the gap, so only a lower bound holds
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= 1'b0;
      seen_q <= 1'b0;
      gap_q  <= 32'h0000_0000;
    end else begin
      pend_q <= vector_valid ? !instr_done : pend_q && !instr_done;
      seen_q <= seen_q || rtc_pulse;
      gap_q  <= rtc_pulse ? 32'h0000_0001 : gap_q + 32'h0000_0001;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ack_onehot: assert property ($onehot0(level_ack))
    else $error("several levels acknowledged");
  a_vec_pair: assert property (vector_valid == (level_ack != 8'h00))
    else $error("vector strobe without matching ack");
  a_ack_after_done: assert property (vector_valid |-> $past(instr_done))
    else $error("recognition outside instruction end");
  a_vec_addr: assert property (vector_valid |-> vector_addr[2:0] == 3'h0
    && level_ack == (8'h01 << (vector_addr >> 3))) else $error("vector address wrong");
  a_first_instr: assert property ((pend_q || vector_valid) && instr_done |=> !vector_valid)
    else $error("first routine instruction interrupted");
  a_ack_single: assert property (vector_valid |=> !vector_valid)
    else $error("ack longer than one cycle");
  a_mask_all_blocks: assert property (instr_done && mask_all_instr && !unmask_all_instr
    && !return_unmask_instr |=> level_ack[7:1] == 7'h00) else $error("masked level taken");
  a_rtc_gap: assert property (rtc_pulse && seen_q |-> gap_q >= RTC_CYCLES)
    else $error("clock pulses too close");
  c_top_level: cover property (vector_valid && vector_addr == 8'h38);
  c_level_zero: cover property (level_ack[0]);
  c_rtc_twice: cover property (rtc_pulse && seen_q);
endmodule
bind prio_int prio_int_chk #(.RTC_CYCLES(RTC_CYCLES)) u_prio_int_chk (.aclk, .aresetn,
  .instr_done, .mask_all_instr, .unmask_all_instr, .return_unmask_instr, .level_ack,
  .vector_valid, .vector_addr, .rtc_pulse);
`default_nettype wire

// ==== testbench/prio_int_tb.sv ====
// self-checking bench for the priority interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "prio_int_defines.vh"
module prio_int_tb;
  localparam logic [31:0] RTC_CYC = 32'h0000_0014;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, rtc_strap, instr_done, mask_all_instr, unmask_all_instr;
  logic return_unmask_instr, out_strobe, vector_valid, watchdog, rtc_pulse, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, level_req, set_req, level_ack;
  logic [7:0] out_dev, out_data, vector_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int tests_run, err_total, cyc, n;
  prio_int #(
    .RTC_CYCLES (RTC_CYC)
  ) u_prio_int (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .s_axi_awaddr        (s_axi_awaddr),
    .s_axi_awvalid       (s_axi_awvalid),
    .s_axi_awready       (s_axi_awready),
    .s_axi_wdata         (s_axi_wdata),
    .s_axi_wstrb         (s_axi_wstrb),
    .s_axi_wvalid        (s_axi_wvalid),
    .s_axi_wready        (s_axi_wready),
    .s_axi_bresp         (s_axi_bresp),
    .s_axi_bvalid        (s_axi_bvalid),
    .s_axi_bready        (s_axi_bready),
    .s_axi_araddr        (s_axi_araddr),
    .s_axi_arvalid       (s_axi_arvalid),
    .s_axi_arready       (s_axi_arready),
    .s_axi_rdata         (s_axi_rdata),
    .s_axi_rresp         (s_axi_rresp),
    .s_axi_rvalid        (s_axi_rvalid),
    .s_axi_rready        (s_axi_rready),
    .level_req           (level_req),
    .rtc_strap           (rtc_strap),
    .instr_done          (instr_done),
    .mask_all_instr      (mask_all_instr),
    .unmask_all_instr    (unmask_all_instr),
    .return_unmask_instr (return_unmask_instr),
    .out_strobe          (out_strobe),
    .out_dev             (out_dev),
    .out_data            (out_data),
    .level_ack           (level_ack),
    .vector_valid        (vector_valid),
    .vector_addr         (vector_addr),
    .watchdog            (watchdog),
    .rtc_pulse           (rtc_pulse),
    .irq                 (irq)
  );
  card_model u_card_model (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .set_req   (set_req),
    .level_ack (level_ack),
    .level_req (level_req)
  );
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
    s_axi_rready <= 1'b0;
  endtask
  // one instruction end; k = {return_unmask, unmask_all, mask_all}
  task automatic step(input logic [2:0] k, input int lvl);
    repeat (2) @(posedge aclk);
    @(posedge aclk);
    instr_done <= 1'b1;
    {return_unmask_instr, unmask_all_instr, mask_all_instr} <= k;
    @(posedge aclk);
    instr_done <= 1'b0;
    {return_unmask_instr, unmask_all_instr, mask_all_instr} <= 3'b000;
    #1;
    chk({vector_valid, level_ack}, lvl < 0 ? 9'h000 : {1'b1, 8'h01 << lvl});
    if (lvl >= 0) chk(vector_addr, 8 * lvl);
  endtask
  task automatic raise(input logic [7:0] m);
    @(posedge aclk);
    set_req <= m;
    @(posedge aclk);
    set_req <= 8'h00;
    repeat (3) @(posedge aclk);
  endtask
  task automatic out_wr(input logic [7:0] dev, input logic [7:0] d);
    @(posedge aclk);
    {out_strobe, out_dev, out_data} <= {1'b1, dev, d};
    @(posedge aclk);
    out_strobe <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic wait_pulse;
    n = 0;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (!rtc_pulse);
  endtask
  initial begin
    aresetn = 1'b0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, set_req, out_dev, out_data} = '0;
    {rtc_strap, instr_done, mask_all_instr, unmask_all_instr} = '0;
    {return_unmask_instr, out_strobe} = '0;
    {tests_run, err_total, cyc} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rchk(8'(i * 4), 32'h0, i < 5 ? `RESP_OKAY : `RESP_SLVERR);
    raise(8'h09);
    step(3'b000, 0);
    step(3'b000, -1);
    out_wr(8'h16, 8'h09);
    step(3'b000, -1);
    out_wr(`ENABLE_DEV_ADDR, 8'h09);
    chk(watchdog, 1'b1);
    step(3'b000, 3);
    out_wr(`ENABLE_DEV_ADDR, 8'hFE);
    chk(watchdog, 1'b0);
    step(3'b001, -1);
    raise(8'hA3);
    step(3'b000, 0);
    step(3'b000, -1);
    step(3'b010, 7);
    step(3'b000, -1);
    step(3'b000, 5);
    step(3'b000, -1);
    step(3'b000, 1);
    step(3'b001, -1);
    raise(8'h04);
    step(3'b100, 2);
    chk(irq, 1'b0);
    axw(`REG_INT_MASK, 32'h0000_0004, rs);
    rchk(`REG_INT_MASK, 32'h0000_0004, `RESP_OKAY);
    chk(irq, 1'b1);
    axw(`REG_INT_STATUS, 32'h0000_0004, rs);
    chk(irq, 1'b0);
    rchk(`REG_INT_STATUS, 32'h0000_00AB, `RESP_OKAY);
    axw(8'h20, 32'h0000_0001, rs);
    chk(rs, `RESP_SLVERR);
    rchk(`REG_ENABLE, 32'h0000_00FE, `RESP_OKAY);
    axw(`REG_CONTROL, 32'h0000_0001, rs);
    rchk(`REG_STATE, 32'h0000_0300, `RESP_OKAY);
    axw(`REG_CONTROL, 32'h0000_0002, rs);
    chk(rs, `RESP_OKAY);
    rtc_strap <= 1'b1;
    wait_pulse();
    wait_pulse();
    chk(n, RTC_CYC);
    step(3'b000, -1);
    step(3'b000, 7);
    step(3'b001, -1);
    step(3'b010, -1);
    wait_pulse();
    chk(n, RTC_CYC + 1);
    report_and_stop();
  end
endmodule
`default_nettype wire
